/* File: design/pms_seq.sv */
// power mode sequencer with apb registers
//
// Operation
// - slow stable bit; while clear no entry to save, idle or halt
// - main oscillator stable bit; while clear no entry to active
// - pll bit set when stable or disabled; clear blocks active
// - upper status bits clear at reset, low bits show clock state
// - immediate save entry; request bit reads set when complete
// - wait-gated save request sets bit at once; enters on wait
// - idle entered by idle bit plus wait, from active or save
// - halt entered by halt bit plus wait, from active or save
// - clock-disable takes effect only after low mode entered
// - main oscillator on in active, off in halt, always
// - clearing save request starts return; bit changes at active
// - wake: clear main disable, wait, clear pll disable, wait
// - nmi or wake event takes save, idle, halt to active
// - wake event latched until interrupt acknowledge or reset
// - wake restores clocks only; handler resumes execution
// - entry to a mode with a clear status bit is held off
// - without slow crystal, slow clock from main; stop only in halt
// - without slow crystal, leaving halt or idle reaches active
// - control byte layout bit 7 down to 0, all clear at reset
// - halt bit cleared by hardware once oscillator is stable
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "pms_defines.svh"
module pms_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_osc_ok,
  input wire logic main_osc_ok,
  input wire logic pll_lock,
  input wire logic pll_pwr_down,
  input wire logic slow_crystal_in,
  input wire logic wait_exec,
  input wire logic nmi,
  input wire logic wake_req,
  input wire logic int_ack,
  output logic main_osc_en,
  output logic pll_en,
  output logic cpu_clk_en,
  output logic slow_from_main,
  output logic wake_pending,
  output pms_pkg::pms_mode_t mode
);
  pms_pkg::pms_state_t state_reg;
  pms_pkg::pms_state_t state_next;
  logic [7:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic xtal_reg;
  logic xtal_done_reg;
  logic wait_reg;
  logic [7:0] wd;
  logic wr_ctrl;
  logic mapped;
  logic slow_ok;
  logic main_ok;
  logic pll_ok;
  logic [7:0] stat;
  logic low_go;
  logic go_ps;
  logic ps_exit;

  pms_stab_if main_if ();
  pms_stab_if pll_if ();

  // ****************************************
  // clock monitors and wake latch
  // ****************************************
  pms_stab #(.CYC(`PMS_MAIN_CYC)) u_main (
    .pclk(pclk),
    .presetn(presetn),
    .stab(main_if.mon)
  );

  pms_stab #(.CYC(`PMS_PLL_CYC)) u_pll (
    .pclk(pclk),
    .presetn(presetn),
    .stab(pll_if.mon)
  );

  pms_wake u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .nmi(nmi),
    .wake_req(wake_req),
    .int_ack(int_ack),
    .wake_pend(wake_pending)
  );

  assign main_if.run = main_osc_en && main_osc_ok;
  assign pll_if.run = pll_en && pll_lock;
  assign main_ok = main_if.stable;
  assign pll_ok = !pll_en || pll_if.stable;
  // prescaled slow clock is good whenever main clock is
  assign slow_ok = xtal_reg ? slow_osc_ok : main_ok;
  assign stat = {5'h00, pll_ok, main_ok, slow_ok};
  assign slow_from_main = !xtal_reg;

  // ****************************************
  // crystal detection
  // ****************************************
  // pin tied low means no crystal; caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_reg <= 1'b0;
      xtal_done_reg <= 1'b0;
    end else if (!xtal_done_reg) begin
      xtal_reg <= slow_crystal_in;
      xtal_done_reg <= 1'b1;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  assign mapped = (paddr == 16'(`PMS_CTRL_ADDR)) ||
                  (paddr == 16'(`PMS_STAT_ADDR));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign wd = pwdata[7:0];
  assign wr_ctrl = psel && penable && pwrite &&
                   (paddr == 16'(`PMS_CTRL_ADDR));

  // read data sampled in setup so it is steady in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == 16'(`PMS_CTRL_ADDR)) begin
        prdata_reg <= {24'h000000, ctrl_reg};
      end else if (paddr == 16'(`PMS_STAT_ADDR)) begin
        prdata_reg <= {24'h000000, stat};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // mode sequencing
  // ****************************************
  // immediate save entry and software exit, decoded from the write
  assign go_ps = wr_ctrl && wd[`PMS_B_PSM] && !wd[`PMS_B_WBPS] &&
                 state_reg == pms_pkg::PMS_ACTIVE;
  assign ps_exit = wr_ctrl && !wd[`PMS_B_PSM] &&
                   state_reg == pms_pkg::PMS_PSAVE;
  // wait entry needs wait-gated bit and a stable slow clock
  assign low_go = wait_reg && ctrl_reg[`PMS_B_WBPS] && slow_ok;

  // wait kept pending only while a missing slow clock holds entry off;
  // a wait with the wait-gated bit clear must not fire a later request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 1'b0;
    end else if (wait_exec) begin
      wait_reg <= 1'b1;
    end else if (state_next != state_reg || !ctrl_reg[`PMS_B_WBPS] ||
                 slow_ok) begin
      wait_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pms_pkg::PMS_ACTIVE: begin
        if (go_ps) begin
          state_next = pms_pkg::PMS_PS_GO;
        end else if (low_go && ctrl_reg[`PMS_B_HALT]) begin
          state_next = pms_pkg::PMS_HALT;
        end else if (low_go && ctrl_reg[`PMS_B_IDLE]) begin
          state_next = pms_pkg::PMS_IDLE;
        end else if (low_go && ctrl_reg[`PMS_B_PSM]) begin
          state_next = pms_pkg::PMS_PSAVE;
        end
      end
      pms_pkg::PMS_PS_GO: begin
        if (slow_ok) begin
          state_next = pms_pkg::PMS_PSAVE;
        end
      end
      pms_pkg::PMS_PSAVE: begin
        if (wake_pending) begin
          state_next = pms_pkg::PMS_WK_MAIN;
        end else if (ps_exit) begin
          state_next = pms_pkg::PMS_PS_EXIT;
        end else if (low_go && ctrl_reg[`PMS_B_HALT]) begin
          state_next = pms_pkg::PMS_HALT;
        end else if (low_go && ctrl_reg[`PMS_B_IDLE]) begin
          state_next = pms_pkg::PMS_IDLE;
        end
      end
      pms_pkg::PMS_IDLE, pms_pkg::PMS_HALT: begin
        if (wake_pending) begin
          state_next = pms_pkg::PMS_WK_MAIN;
        end
      end
      pms_pkg::PMS_WK_MAIN: begin
        if (main_ok) begin
          state_next = pms_pkg::PMS_WK_PLL;
        end
      end
      pms_pkg::PMS_WK_PLL, pms_pkg::PMS_PS_EXIT: begin
        if (main_ok && pll_ok) begin
          state_next = pms_pkg::PMS_ACTIVE;
        end
      end
      default: begin
        state_next = pms_pkg::PMS_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pms_pkg::PMS_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // hardware updates come last so they win over a colliding write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PMS_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[7:1] <= wd[7:1];
        // psm takes a wait-gated request at once; other changes read only once the switch is done
        if (state_reg == pms_pkg::PMS_ACTIVE) begin
          ctrl_reg[`PMS_B_PSM] <= wd[`PMS_B_PSM] &&
                                  wd[`PMS_B_WBPS];
        end
      end
      if (state_reg == pms_pkg::PMS_PS_GO &&
          state_next == pms_pkg::PMS_PSAVE) begin
        ctrl_reg[`PMS_B_PSM] <= 1'b1;
      end
      if (state_reg == pms_pkg::PMS_WK_MAIN) begin
        ctrl_reg[`PMS_B_DMC] <= 1'b0;
      end
      if (state_reg == pms_pkg::PMS_WK_MAIN && main_ok) begin
        ctrl_reg[`PMS_B_DHC] <= 1'b0;
        ctrl_reg[`PMS_B_HALT] <= 1'b0;
      end
      if (state_reg != pms_pkg::PMS_ACTIVE &&
          state_next == pms_pkg::PMS_ACTIVE) begin
        ctrl_reg[`PMS_B_PSM] <= 1'b0;
        ctrl_reg[`PMS_B_IDLE] <= 1'b0;
        ctrl_reg[`PMS_B_HALT] <= 1'b0;
        ctrl_reg[`PMS_B_OSC_HW_CONTROL] <= 1'b0;
        ctrl_reg[`PMS_B_PLL_HW_CONTROL] <= 1'b0;
      end
    end
  end

  // ****************************************
  // clock enables and mode
  // ****************************************
  // disables act in save and idle, the pll one also while main wakes; never before entry
  always_comb begin
    main_osc_en = 1'b1;
    pll_en = !pll_pwr_down;
    cpu_clk_en = 1'b1;
    mode = pms_pkg::PMS_M_ACTIVE;
    case (state_reg)
      pms_pkg::PMS_PSAVE, pms_pkg::PMS_IDLE: begin
        // without crystal the slow clock depends on the main clock
        main_osc_en = !(ctrl_reg[`PMS_B_DMC] && xtal_reg);
        pll_en = !pll_pwr_down && !ctrl_reg[`PMS_B_DHC];
        cpu_clk_en = state_reg == pms_pkg::PMS_PSAVE;
        mode = state_reg == pms_pkg::PMS_PSAVE ? pms_pkg::PMS_M_PSAVE :
               pms_pkg::PMS_M_IDLE;
      end
      pms_pkg::PMS_HALT: begin
        main_osc_en = 1'b0;
        pll_en = 1'b0;
        cpu_clk_en = 1'b0;
        mode = pms_pkg::PMS_M_HALT;
      end
      pms_pkg::PMS_WK_MAIN: begin
        pll_en = !pll_pwr_down && !ctrl_reg[`PMS_B_DHC];
        cpu_clk_en = 1'b0;
        mode = pms_pkg::PMS_M_HALT;
      end
      pms_pkg::PMS_WK_PLL: begin
        cpu_clk_en = 1'b0;
        mode = pms_pkg::PMS_M_HALT;
      end
      pms_pkg::PMS_PS_EXIT: begin
        mode = pms_pkg::PMS_M_PSAVE;
      end
      default: begin
        mode = pms_pkg::PMS_M_ACTIVE;
      end
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  slow_gate_a: assert property (
    (state_next inside {pms_pkg::PMS_PSAVE, pms_pkg::PMS_IDLE,
     pms_pkg::PMS_HALT} && state_next != state_reg) |-> slow_ok)
    else $error("low power entered without slow clock");
  clk_gate_a: assert property (
    (state_next == pms_pkg::PMS_ACTIVE &&
     state_reg != pms_pkg::PMS_ACTIVE) |-> (main_ok && pll_ok))
    else $error("active entered without stable clocks");
  psm_imm_a: assert property (
    go_ps |=> state_reg == pms_pkg::PMS_PS_GO &&
    !ctrl_reg[`PMS_B_PSM])
    else $error("immediate save request mishandled");
  psm_gate_a: assert property (
    (wr_ctrl && wd[`PMS_B_PSM] && wd[`PMS_B_WBPS] && !low_go &&
     state_reg == pms_pkg::PMS_ACTIVE) |=>
    ctrl_reg[`PMS_B_PSM] && state_reg == pms_pkg::PMS_ACTIVE)
    else $error("wait gated save request not set");
  osc_mode_a: assert property (
    (state_reg == pms_pkg::PMS_HALT) |-> !main_osc_en && !pll_en)
    else $error("oscillator running in halt");
  wake_exit_a: assert property (
    (wake_pending && state_reg inside {pms_pkg::PMS_IDLE,
     pms_pkg::PMS_HALT}) |=> state_reg == pms_pkg::PMS_WK_MAIN)
    else $error("wake not taken");
  wake_hold_a: assert property (
    (wake_pending && !int_ack) |=> wake_pending)
    else $error("wake latch lost");
  halt_clr_a: assert property (
    (state_reg == pms_pkg::PMS_WK_MAIN && main_ok) |=>
    !ctrl_reg[`PMS_B_HALT] && !ctrl_reg[`PMS_B_DHC])
    else $error("halt bit not cleared after oscillator stable");
  noxtal_a: assert property (
    (!xtal_reg && state_reg != pms_pkg::PMS_HALT) |-> main_osc_en)
    else $error("main clock stopped without slow crystal");
  exit_psm_a: assert property (
    (ps_exit && !wake_pending) |=> ctrl_reg[`PMS_B_PSM] [*1] ##0
    state_reg == pms_pkg::PMS_PS_EXIT)
    else $error("save exit changed bit early");

  cover property (state_reg == pms_pkg::PMS_PS_GO ##[1:200]
    state_reg == pms_pkg::PMS_PSAVE);
  cover property (state_reg == pms_pkg::PMS_HALT ##[1:500]
    state_reg == pms_pkg::PMS_ACTIVE);
  cover property (state_reg == pms_pkg::PMS_PS_EXIT ##[1:500]
    state_reg == pms_pkg::PMS_ACTIVE);
endmodule

/* File: design/pms_defines.svh */
// register map, field positions, reset values and timing counts
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

`define PMS_ADDR_W 16
// register indices; byte address is four times the index
`define PMS_CTRL_IDX 16'h0c60
`define PMS_STAT_IDX 16'h0c62
`define PMS_CTRL_ADDR (`PMS_CTRL_IDX * 4)
`define PMS_STAT_ADDR (`PMS_STAT_IDX * 4)

// control register fields
`define PMS_B_PSM 0
`define PMS_B_IDLE 1
`define PMS_B_HALT 2
`define PMS_B_WBPS 3
`define PMS_B_DMC 4
`define PMS_B_DHC 5
`define PMS_B_OSC_HW_CONTROL 6
`define PMS_B_PLL_HW_CONTROL 7
`define PMS_CTRL_RST 8'h00

// status register fields
`define PMS_B_SLOW 0
`define PMS_B_MAIN 1
`define PMS_B_PLL 2

// settle times and the clock period
`define PMS_CLK_NS 20
`define PMS_MAIN_SETTLE_NS 2000
`define PMS_PLL_SETTLE_NS 1000
`define PMS_MAIN_CYC ((`PMS_MAIN_SETTLE_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_PLL_CYC ((`PMS_PLL_SETTLE_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)

`endif

/* File: design/pms_pkg.sv */
// types of the power mode sequencer
package pms_pkg;

  // gray coded along active -> save -> idle -> halt -> wake path
  typedef enum logic [2:0] {
    PMS_ACTIVE = 3'h0,
    PMS_PS_GO = 3'h1,
    PMS_PSAVE = 3'h3,
    PMS_IDLE = 3'h2,
    PMS_HALT = 3'h6,
    PMS_WK_MAIN = 3'h7,
    PMS_WK_PLL = 3'h5,
    PMS_PS_EXIT = 3'h4
  } pms_state_t;

  typedef enum logic [1:0] {
    PMS_M_ACTIVE = 2'h0,
    PMS_M_PSAVE = 2'h1,
    PMS_M_IDLE = 2'h2,
    PMS_M_HALT = 2'h3
  } pms_mode_t;

endpackage

/* File: design/pms_stab_if.sv */
// carrier between the sequencer and a clock stability monitor
`timescale 1ns/1ps
interface pms_stab_if;
  logic run;
  logic stable;
  modport ctl (output run, input stable);
  modport mon (input run, output stable);
endinterface

/* File: design/pms_stab.sv */
// stability monitor: stable after CYC cycles of uninterrupted run
`timescale 1ns/1ps
module pms_stab #(
  parameter int CYC = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  pms_stab_if.mon stab
);
  logic [11:0] cnt_reg;

  // any drop of enable or oscillator restarts the settle time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 12'h000;
    end else if (!stab.run) begin
      cnt_reg <= 12'h000;
    end else if (cnt_reg != 12'(CYC)) begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  assign stab.stable = stab.run && (cnt_reg == 12'(CYC));
endmodule

/* File: design/pms_wake.sv */
// wake event latch: held until interrupt acknowledge or reset
`timescale 1ns/1ps
module pms_wake (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nmi,
  input wire logic wake_req,
  input wire logic int_ack,
  output logic wake_pend
);
  // a new event in the acknowledge cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pend <= 1'b0;
    end else if (nmi || wake_req) begin
      wake_pend <= 1'b1;
    end else if (int_ack) begin
      wake_pend <= 1'b0;
    end
  end
endmodule

/* File: tb/pms_partner.sv */
// cpu, wake-up source and oscillator start-up model for the sequencer
`timescale 1ns/1ps
module pms_partner #(
  parameter int START = 4
) (
  input wire logic pclk,
  input wire logic main_osc_en,
  input wire logic pll_en,
  output logic main_osc_ok,
  output logic pll_lock,
  output logic wait_exec,
  output logic nmi,
  output logic wake_req,
  output logic int_ack
);
  // ************************************************************
  // oscillators
  // ************************************************************
  // a disabled source reports not-ok at once, never a stale good level
  logic [START-1:0] main_sr;
  logic [START-1:0] pll_sr;

  initial begin
    main_sr = '0;
    pll_sr = '0;
    wait_exec = 1'h0;
    nmi = 1'h0;
    wake_req = 1'h0;
    int_ack = 1'h0;
  end

  always @(posedge pclk) begin
    main_sr <= main_osc_en ? {main_sr[START-2:0], 1'h1} : '0;
    pll_sr <= pll_en ? {pll_sr[START-2:0], 1'h1} : '0;
  end

  assign main_osc_ok = main_sr[START-1] & main_osc_en;
  assign pll_lock = pll_sr[START-1] & pll_en;

  // ************************************************************
  // cpu and wake-up pulses
  // ************************************************************
  // wait only ever follows a completed register write
  task automatic exec_wait();
    @(posedge pclk);
    wait_exec <= 1'h1;
    @(posedge pclk);
    wait_exec <= 1'h0;
  endtask

  task automatic wake();
    @(posedge pclk);
    wake_req <= 1'h1;
    @(posedge pclk);
    wake_req <= 1'h0;
  endtask

  task automatic nmi_pulse();
    @(posedge pclk);
    nmi <= 1'h1;
    @(posedge pclk);
    nmi <= 1'h0;
  endtask

  task automatic ack();
    @(posedge pclk);
    int_ack <= 1'h1;
    @(posedge pclk);
    int_ack <= 1'h0;
  endtask
endmodule

/* File: tb/power_mode_sequencer_test.sv */
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`include "pms_defines.svh"
module power_mode_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, slow_osc_ok, main_osc_ok, pll_lock, pll_pwr_down;
  logic slow_crystal_in, wait_exec, nmi, wake_req, int_ack;
  logic main_osc_en, pll_en, cpu_clk_en, slow_from_main, wake_pending;
  pms_pkg::pms_mode_t mode;
  int err_total = 0;
  int n_tests = 0;

  pms_seq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc_ok(slow_osc_ok), .main_osc_ok(main_osc_ok),
    .pll_lock(pll_lock), .pll_pwr_down(pll_pwr_down),
    .slow_crystal_in(slow_crystal_in), .wait_exec(wait_exec), .nmi(nmi),
    .wake_req(wake_req), .int_ack(int_ack), .main_osc_en(main_osc_en),
    .pll_en(pll_en), .cpu_clk_en(cpu_clk_en),
    .slow_from_main(slow_from_main), .wake_pending(wake_pending),
    .mode(mode));

  pms_partner i_peer (.pclk(pclk), .main_osc_en(main_osc_en),
    .pll_en(pll_en), .main_osc_ok(main_osc_ok), .pll_lock(pll_lock),
    .wait_exec(wait_exec), .nmi(nmi), .wake_req(wake_req),
    .int_ack(int_ack));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a,
      input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h00);
    chk(rd, exp);
  endtask

  // software side: re-read status until the given bit reads set
  task automatic poll_stat(input int b);
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'h0, `PMS_STAT_ADDR, 8'h00);
      if (rd[b] === 1'h1) break;
    end
    chk(32'(rd[b]), 32'h1);
  endtask

  task automatic wait_mode(input pms_pkg::pms_mode_t m);
    int i;
    for (i = 0; i < 400 && mode !== m; i++) @(negedge pclk);
    chk(32'(mode), 32'(m));
  endtask

  // settle long enough for both stability monitors to count out
  task automatic do_reset(input logic xtal);
    @(posedge pclk);
    presetn <= 1'h0;
    slow_crystal_in <= xtal;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (200) @(posedge pclk);
    @(negedge pclk);
  endtask

  // ************************************************************
  // clock and watchdog
  // ************************************************************
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    slow_osc_ok = 1'h1;
    pll_pwr_down = 1'h0;
    slow_crystal_in = 1'h1;
    do_reset(1'h1);
    chk(32'(slow_from_main), 32'h0);
    rdc(`PMS_CTRL_ADDR, 32'h00);
    rdc(`PMS_STAT_ADDR, 32'h07);
    rdc(16'h0000, 32'h00);
    chk(32'(er), 32'h1);
    chk(32'(pready), 32'h1);
    slow_osc_ok <= 1'h0;
    repeat (3) @(posedge pclk);
    rdc(`PMS_STAT_ADDR, 32'h06);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h01);
    repeat (20) @(negedge pclk);
    chk(32'(mode), 32'(pms_pkg::PMS_M_ACTIVE));
    rdc(`PMS_CTRL_ADDR, 32'h00);
    slow_osc_ok <= 1'h1;
    wait_mode(pms_pkg::PMS_M_PSAVE);
    rdc(`PMS_CTRL_ADDR, 32'h01);
    chk(32'(cpu_clk_en), 32'h1);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h11);
    repeat (3) @(negedge pclk);
    chk(32'(main_osc_en), 32'h0);
    // exit requested before the oscillator is back: must be held off
    apb(1'h1, `PMS_CTRL_ADDR, 8'h01);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h00);
    repeat (20) @(negedge pclk);
    chk(32'(mode), 32'(pms_pkg::PMS_M_PSAVE));
    rdc(`PMS_CTRL_ADDR, 32'h01);
    wait_mode(pms_pkg::PMS_M_ACTIVE);
    rdc(`PMS_CTRL_ADDR, 32'h00);
    // compliant exit: oscillator back and stable before the request clears
    poll_stat(`PMS_B_SLOW);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h01);
    wait_mode(pms_pkg::PMS_M_PSAVE);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h11);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h01);
    poll_stat(`PMS_B_MAIN);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h00);
    repeat (3) @(negedge pclk);
    chk(32'(mode), 32'(pms_pkg::PMS_M_ACTIVE));
    // halt taken straight from power save
    apb(1'h1, `PMS_CTRL_ADDR, 8'h01);
    wait_mode(pms_pkg::PMS_M_PSAVE);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h0d);
    i_peer.exec_wait();
    wait_mode(pms_pkg::PMS_M_HALT);
    i_peer.nmi_pulse();
    wait_mode(pms_pkg::PMS_M_ACTIVE);
    i_peer.ack();
    apb(1'h1, `PMS_CTRL_ADDR, 8'h09);
    rdc(`PMS_CTRL_ADDR, 32'h09);
    chk(32'(mode), 32'(pms_pkg::PMS_M_ACTIVE));
    i_peer.exec_wait();
    wait_mode(pms_pkg::PMS_M_PSAVE);
    i_peer.wake();
    wait_mode(pms_pkg::PMS_M_ACTIVE);
    chk(32'(wake_pending), 32'h1);
    rdc(`PMS_CTRL_ADDR, 32'h08);
    i_peer.ack();
    @(negedge pclk);
    chk(32'(wake_pending), 32'h0);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h3c);
    i_peer.exec_wait();
    wait_mode(pms_pkg::PMS_M_HALT);
    chk(32'({main_osc_en, pll_en}), 32'h0);
    i_peer.nmi_pulse();
    repeat (3) @(negedge pclk);
    chk(32'({main_osc_en, cpu_clk_en}), 32'h2);
    rdc(`PMS_CTRL_ADDR, 32'h2c);
    wait_mode(pms_pkg::PMS_M_ACTIVE);
    rdc(`PMS_CTRL_ADDR, 32'h08);
    i_peer.ack();
    apb(1'h1, `PMS_CTRL_ADDR, 8'h1a);
    @(negedge pclk);
    chk(32'(main_osc_en), 32'h1);
    i_peer.exec_wait();
    wait_mode(pms_pkg::PMS_M_IDLE);
    chk(32'(main_osc_en), 32'h0);
    i_peer.wake();
    wait_mode(pms_pkg::PMS_M_ACTIVE);
    i_peer.ack();
    pll_pwr_down <= 1'h1;
    repeat (10) @(posedge pclk);
    rdc(`PMS_STAT_ADDR, 32'h07);
    pll_pwr_down <= 1'h0;
    // no slow crystal: main clock must keep running in idle
    do_reset(1'h0);
    chk(32'(slow_from_main), 32'h1);
    apb(1'h1, `PMS_CTRL_ADDR, 8'h1a);
    i_peer.exec_wait();
    wait_mode(pms_pkg::PMS_M_IDLE);
    chk(32'(main_osc_en), 32'h1);
    i_peer.wake();
    wait_mode(pms_pkg::PMS_M_ACTIVE);
    chk(32'(slow_from_main), 32'h1);
    i_peer.ack();
    tally_and_finish();
  end
endmodule
